/* shared/upm_map.svh */
`ifndef UPM_MAP_SVH
`define UPM_MAP_SVH
// ****************************************
// register byte offsets
// ****************************************
`define UPM_OFF_GENCTL 12'h000
`define UPM_OFF_ACTL 12'h004
`define UPM_OFF_BCTL 12'h008
`define UPM_OFF_ADIR 12'h00C
`define UPM_OFF_BDIR 12'h010
`define UPM_OFF_ADATA 12'h014
`define UPM_OFF_BDATA 12'h018
`define UPM_OFF_STATUS 12'h01C
`define UPM_OFF_APIN 12'h020
`define UPM_OFF_BPIN 12'h024
// ****************************************
// control register fields
// ****************************************
`define UPM_SUB_HI 7
`define UPM_SUB_LO 6
`define UPM_SEC_HI 5
`define UPM_SEC_LO 3
`define UPM_IEN_BIT 2
`define UPM_SVC_BIT 1
// ****************************************
// general control fields
// ****************************************
`define UPM_GEN_AEN 4
`define UPM_GEN_BEN 5
`define UPM_GEN_DMAB 6
// ****************************************
// status fields: a strobe, a second, b strobe, b second
// ****************************************
`define UPM_ST_ASTB 0
`define UPM_ST_ASEC 1
`define UPM_ST_BSTB 2
`define UPM_ST_BSEC 3
// ****************************************
// timing
// ****************************************
`define UPM_CLK_NS 5
`define UPM_PULSE_CYC 3'h4
`endif

/* shared/upm_pkg.sv */
package upm_pkg;
  typedef enum logic [1:0] {UPM_SUB_IN, UPM_SUB_OUT, UPM_SUB_BIT, UPM_SUB_BIT2} upm_sub_e;
  typedef enum logic [2:0] {UPM_SEC_E0, UPM_SEC_E1, UPM_SEC_E2, UPM_SEC_E3,
                            UPM_SEC_NEG, UPM_SEC_ASS, UPM_SEC_ILK, UPM_SEC_PLS} upm_sec_e;
endpackage

/* core/upm_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "upm_map.svh"
module upm_port #(
  parameter int DW = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // port a pins
  input wire logic [DW-1:0] port_a_in,
  output logic [DW-1:0] port_a_out,
  output logic [DW-1:0] port_a_oe,
  input wire logic port_a_strobe_in,
  input wire logic port_a_second_in,
  output logic port_a_second_pin,
  output logic port_a_second_oe,
  // port b pins
  input wire logic [DW-1:0] port_b_in,
  output logic [DW-1:0] port_b_out,
  output logic [DW-1:0] port_b_oe,
  input wire logic port_b_strobe_in,
  input wire logic port_b_second_in,
  output logic port_b_second_pin,
  output logic port_b_second_oe,
  // requests
  output logic port_irq,
  output logic dma_request_out
);
  // ****************************************
  // registers and bus decode
  // ****************************************
  logic [7:0] gen_ctl;
  logic [7:0] ctl [2];
  logic [DW-1:0] dir [2];
  logic [DW-1:0] final_output_latch [2];
  logic [DW-1:0] initial_output_latch [2];
  logic iol_full [2];
  logic [DW-1:0] final_input_latch [2];
  logic [DW-1:0] iil [2];
  logic [1:0] cnt [2];
  logic sec_flag [2];
  logic stb_flag_bit [2];
  logic [2:0] pulse_cnt [2];
  logic hs_out [2];
  logic [2:0] sync_s [2];
  logic [2:0] sync_h [2];
  logic [DW-1:0] pin_in [2];
  logic [3:0] port_status_register;
  logic wr_en;
  logic rd_en;
  logic mapped;
  assign pin_in[0] = port_a_in;
  assign pin_in[1] = port_b_in;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign pready = 1'b1;
  always_comb begin
    unique case (paddr)
      `UPM_OFF_GENCTL, `UPM_OFF_ACTL, `UPM_OFF_BCTL, `UPM_OFF_ADIR, `UPM_OFF_BDIR,
      `UPM_OFF_ADATA, `UPM_OFF_BDATA, `UPM_OFF_STATUS, `UPM_OFF_APIN, `UPM_OFF_BPIN: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~mapped;

  function automatic logic en_of(input logic [7:0] g, input int p);
    en_of = p == 0 ? g[`UPM_GEN_AEN] : g[`UPM_GEN_BEN];
  endfunction

  function automatic upm_pkg::upm_sub_e sub_of(input logic [7:0] c);
    sub_of = upm_pkg::upm_sub_e'(c[`UPM_SUB_HI:`UPM_SUB_LO]);
  endfunction

  function automatic upm_pkg::upm_sec_e sec_of(input logic [7:0] c);
    sec_of = upm_pkg::upm_sec_e'(c[`UPM_SEC_HI:`UPM_SEC_LO]);
  endfunction

  // read data source per direction bit and submode
  function automatic logic [DW-1:0] data_view(input int p);
    logic [DW-1:0] src;
    src = sub_of(ctl[p]) == upm_pkg::UPM_SUB_IN ? final_input_latch[p] : pin_in[p];
    data_view = (dir[p] & final_output_latch[p]) | (~dir[p] & src);
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gen_ctl <= 8'h00;
    end else if (wr_en && paddr == `UPM_OFF_GENCTL) begin
      gen_ctl <= pwdata[7:0];
    end
  end

  // ****************************************
  // per port logic
  // ****************************************
  logic [1:0] pop;
  logic [1:0] stb_edge;
  logic [1:0] sec_edge;
  logic [1:0] ready_in;
  logic [1:0] stb_flag;
  logic [1:0] second_pin_raw;
  for (genvar p = 0; p < 2; p++) begin : g_port
    localparam logic [11:0] OFF_CTL = p == 0 ? `UPM_OFF_ACTL : `UPM_OFF_BCTL;
    localparam logic [11:0] OFF_DIR = p == 0 ? `UPM_OFF_ADIR : `UPM_OFF_BDIR;
    localparam logic [11:0] OFF_DAT = p == 0 ? `UPM_OFF_ADATA : `UPM_OFF_BDATA;
    localparam int ST_STB = p == 0 ? `UPM_ST_ASTB : `UPM_ST_BSTB;
    localparam int ST_SEC = p == 0 ? `UPM_ST_ASEC : `UPM_ST_BSEC;
    logic en;
    logic stb_sense;
    logic sec_sense;
    logic stb_raw;
    logic sec_raw;
    logic in_mode;
    logic hs_mode;
    logic take;
    assign en = en_of(gen_ctl, p);
    assign stb_sense = gen_ctl[2*p];
    assign sec_sense = gen_ctl[2*p+1];
    // sense zero means active low: an asserted pin must read as a one here
    assign stb_raw = ~((p == 0 ? port_a_strobe_in : port_b_strobe_in) ^ stb_sense);
    assign sec_raw = ~((p == 0 ? port_a_second_in : port_b_second_in) ^ sec_sense);
    assign in_mode = sub_of(ctl[p]) == upm_pkg::UPM_SUB_IN;
    assign hs_mode = sec_of(ctl[p]) == upm_pkg::UPM_SEC_ILK || sec_of(ctl[p]) == upm_pkg::UPM_SEC_PLS;

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        sync_s[p] <= 3'h0;
        sync_h[p] <= 3'h0;
      end else begin
        sync_s[p] <= {sync_s[p][1:0], stb_raw};
        sync_h[p] <= {sync_h[p][1:0], sec_raw};
      end
    end
    assign stb_edge[p] = sync_s[p][1] & ~sync_s[p][2];
    assign sec_edge[p] = sync_h[p][1] & ~sync_h[p][2];
    assign ready_in[p] = cnt[p] != 2'h2;
    // interlocked ignores strobes while pin negated; pulsed takes any while there is room, pulse or no pulse
    assign take = en & in_mode & stb_edge[p] & ready_in[p] &
                  (sec_of(ctl[p]) != upm_pkg::UPM_SEC_ILK | hs_out[p]);
    assign pop[p] = rd_en & paddr == OFF_DAT & in_mode & cnt[p] != 2'h0;

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        ctl[p] <= 8'h00;
        dir[p] <= '0;
      end else if (wr_en) begin
        if (paddr == OFF_CTL) ctl[p] <= pwdata[7:0];
        if (paddr == OFF_DIR) dir[p] <= pwdata[DW-1:0];
      end
    end

    // output side; 01 double-buffered through the initial latch
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        final_output_latch[p] <= '0;
        initial_output_latch[p] <= '0;
        iol_full[p] <= 1'b0;
      end else if (wr_en && paddr == OFF_DAT) begin
        if (sub_of(ctl[p]) == upm_pkg::UPM_SUB_OUT) begin
          initial_output_latch[p] <= pwdata[DW-1:0];
          iol_full[p] <= 1'b1;
        end else begin
          final_output_latch[p] <= pwdata[DW-1:0];
        end
      end else if (iol_full[p]) begin
        final_output_latch[p] <= initial_output_latch[p];
        iol_full[p] <= 1'b0;
      end
    end

    // two-deep input buffer: fil is head, iil behind it
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        cnt[p] <= 2'h0;
        final_input_latch[p] <= '0;
        iil[p] <= '0;
      end else if (!en) begin
        cnt[p] <= 2'h0;
      end else begin
        unique case ({take, pop[p]})
          2'b10: begin
            if (cnt[p] == 2'h0) final_input_latch[p] <= pin_in[p];
            else iil[p] <= pin_in[p];
            cnt[p] <= cnt[p] + 2'h1;
          end
          2'b01: begin
            final_input_latch[p] <= iil[p];
            cnt[p] <= cnt[p] - 2'h1;
          end
          2'b11: begin
            if (cnt[p] == 2'h1) final_input_latch[p] <= pin_in[p];
            else begin
              final_input_latch[p] <= iil[p];
              iil[p] <= pin_in[p];
            end
          end
          default: cnt[p] <= cnt[p];
        endcase
      end
    end
    assign stb_flag[p] = in_mode ? cnt[p] != 2'h0 : stb_flag_bit[p];

    // simple edge flags, set beats clear
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        sec_flag[p] <= 1'b0;
        stb_flag_bit[p] <= 1'b0;
      end else if (!en) begin
        sec_flag[p] <= 1'b0;
        stb_flag_bit[p] <= 1'b0;
      end else begin
        if (!ctl[p][`UPM_SEC_HI]) begin
          if (sec_edge[p]) sec_flag[p] <= 1'b1;
          else if (wr_en && paddr == `UPM_OFF_STATUS && pwdata[ST_SEC]) sec_flag[p] <= 1'b0;
        end else begin
          sec_flag[p] <= 1'b0;
        end
        if (!in_mode) begin
          if (stb_edge[p]) stb_flag_bit[p] <= 1'b1;
          else if (wr_en && paddr == `UPM_OFF_STATUS && pwdata[ST_STB]) stb_flag_bit[p] <= 1'b0;
        end else begin
          stb_flag_bit[p] <= 1'b0;
        end
      end
    end

    // handshake output: raise when room, drop on strobe edge, pulse limit;
    // a pulse that runs out stays spent until the buffer moves, so no endless pulsing
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        hs_out[p] <= 1'b0;
        pulse_cnt[p] <= 3'h0;
      end else if (!en || !hs_mode || !in_mode) begin
        hs_out[p] <= 1'b0;
        pulse_cnt[p] <= 3'h0;
      end else if (hs_out[p]) begin
        if (stb_edge[p] || !ready_in[p]) begin
          hs_out[p] <= 1'b0;
          pulse_cnt[p] <= 3'h0;
        end else if (sec_of(ctl[p]) == upm_pkg::UPM_SEC_PLS) begin
          if (pulse_cnt[p] == `UPM_PULSE_CYC - 3'h1) begin
            hs_out[p] <= 1'b0;
            pulse_cnt[p] <= `UPM_PULSE_CYC;
          end else begin
            pulse_cnt[p] <= pulse_cnt[p] + 3'h1;
          end
        end
      end else if (take || pop[p]) begin
        pulse_cnt[p] <= 3'h0;
      end else if (ready_in[p] && (pulse_cnt[p] != `UPM_PULSE_CYC || sec_of(ctl[p]) != upm_pkg::UPM_SEC_PLS)) begin
        hs_out[p] <= 1'b1;
      end
    end

    // strobe edge in the sync stage drops the pin without waiting a clock
    always_comb begin
      unique case (sec_of(ctl[p]))
        upm_pkg::UPM_SEC_NEG: second_pin_raw[p] = 1'b0;
        upm_pkg::UPM_SEC_ASS: second_pin_raw[p] = 1'b1;
        upm_pkg::UPM_SEC_ILK, upm_pkg::UPM_SEC_PLS: second_pin_raw[p] = hs_out[p] & ~stb_edge[p] & en;
        default: second_pin_raw[p] = 1'b0;
      endcase
    end
    assign port_status_register[ST_STB] = stb_flag[p];
    assign port_status_register[ST_SEC] = sec_flag[p];
  end

  assign port_a_out = final_output_latch[0];
  assign port_b_out = final_output_latch[1];
  assign port_a_oe = dir[0];
  assign port_b_oe = dir[1];
  assign port_a_second_pin = ~(second_pin_raw[0] ^ gen_ctl[1]);
  assign port_b_second_pin = ~(second_pin_raw[1] ^ gen_ctl[3]);
  assign port_a_second_oe = ctl[0][`UPM_SEC_HI];
  assign port_b_second_oe = ctl[1][`UPM_SEC_HI];

  // ****************************************
  // requests
  // ****************************************
  logic dsel;
  assign dsel = gen_ctl[`UPM_GEN_DMAB];
  assign dma_request_out = ctl[dsel][`UPM_SVC_BIT] & ~ctl[dsel][`UPM_SUB_HI] & stb_flag[dsel];
  assign port_irq = (sec_flag[0] & ctl[0][`UPM_IEN_BIT]) | (sec_flag[1] & ctl[1][`UPM_IEN_BIT]) |
                    (stb_flag[0] & ctl[0][`UPM_SVC_BIT] & (dsel | ctl[0][`UPM_SUB_HI])) |
                    (stb_flag[1] & ctl[1][`UPM_SVC_BIT] & (~dsel | ctl[1][`UPM_SUB_HI]));

  // ****************************************
  // read mux, registered
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `UPM_OFF_GENCTL: prdata <= {24'h00_0000, gen_ctl};
        `UPM_OFF_ACTL: prdata <= {24'h00_0000, ctl[0]};
        `UPM_OFF_BCTL: prdata <= {24'h00_0000, ctl[1]};
        `UPM_OFF_ADIR: prdata <= 32'(dir[0]);
        `UPM_OFF_BDIR: prdata <= 32'(dir[1]);
        `UPM_OFF_ADATA: prdata <= 32'(data_view(0));
        `UPM_OFF_BDATA: prdata <= 32'(data_view(1));
        `UPM_OFF_STATUS: prdata <= {28'h000_0000, port_status_register};
        `UPM_OFF_APIN: prdata <= 32'(port_a_in);
        `UPM_OFF_BPIN: prdata <= 32'(port_b_in);
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

/* bench/upm_port_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "upm_map.svh"
module upm_port_check (
  // bus
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // port a and requests
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] port_a_oe,
  input wire logic port_a_strobe_in,
  input wire logic port_a_second_pin,
  input wire logic port_a_second_oe,
  input wire logic dma_request_out
);
  logic [7:0] gen, ca, cb;
  logic [2:0] plen;
  logic wr, asrt;
  assign wr = psel && penable && pwrite;
  assign asrt = port_a_second_pin == gen[1];
  // shadow control copies, taken at the edge the port takes them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gen <= 8'h00;
      ca <= 8'h00;
      cb <= 8'h00;
    end else if (wr) begin
      if (paddr == `UPM_OFF_GENCTL) gen <= pwdata[7:0];
      if (paddr == `UPM_OFF_ACTL) ca <= pwdata[7:0];
      if (paddr == `UPM_OFF_BCTL) cb <= pwdata[7:0];
    end
  end
  // saturates so a stuck pulse cannot wrap back to a legal count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) plen <= 3'h0;
    else if (!asrt || ca[5:3] != 3'b111) plen <= 3'h0;
    else if (plen != 3'h7) plen <= plen + 3'h1;
  end
  default clocking dck @(posedge clk);
  endclocking
  default disable iff (rst);
  a_dir_drives: assert property (wr && paddr == `UPM_OFF_ADIR |=> port_a_oe == $past(pwdata[7:0]))
    else $error("direction write not on enables");
  a_out_single: assert property (wr && paddr == `UPM_OFF_ADATA && ca[7:6] != 2'b01 |=> port_a_out == $past(pwdata[7:0]))
    else $error("data write not on output latch");
  a_second_dir: assert property (port_a_second_oe == ca[5])
    else $error("second pin direction wrong");
  a_fixed_level: assert property (ca[5:4] == 2'b10 |-> port_a_second_pin == !(ca[3] ^ gen[1]))
    else $error("fixed second pin level wrong");
  a_idle_negated: assert property (ca[5:4] == 2'b11 && !gen[4] |-> port_a_second_pin == !gen[1])
    else $error("second pin not negated while disabled");
  a_pulse_len: assert property (plen <= 3'h4)
    else $error("pulse longer than four cycles");
  a_strobe_drop: assert property ($fell(port_a_strobe_in) && !gen[0] && gen[4] && ca[5:3] == 3'b110 |-> ##[1:3] !asrt)
    else $error("second pin kept after strobe");
  a_dma_gate: assert property (!(gen[6] ? cb[1] && !cb[7] : ca[1] && !ca[7]) |-> !dma_request_out)
    else $error("dma request while not allowed");
  a_dma_off: assert property ((!gen[4] && !gen[6]) [*2] |-> !dma_request_out)
    else $error("dma request from disabled port");
endmodule
bind upm_port upm_port_check i_chk (
  .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .port_a_out, .port_a_oe,
  .port_a_strobe_in, .port_a_second_pin, .port_a_second_oe, .dma_request_out
);
`default_nettype wire

/* bench/upm_periph.sv */
`timescale 1ns/1ps
`default_nettype none
module upm_periph (
  // clock and request from the port
  input wire logic clk,
  input wire logic second_pin,
  // lines to the port; strobe and second input active low, data pins active high
  output logic strobe,
  output logic second_in,
  output logic [7:0] pins
);
  initial begin
    strobe = 1'b1;
    second_in = 1'b1;
    pins = 8'h00;
  end
  task automatic send(input logic [7:0] v, input logic rdy, output logic late);
    int n;
    n = 0;
    while (rdy && second_pin !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    late = rdy && second_pin !== 1'b0;
    pins <= v;
    @(posedge clk);
    strobe <= 1'b0;
    repeat (3) @(posedge clk);
    strobe <= 1'b1;
    repeat (2) @(posedge clk);
    // hold time over: never leave the old byte standing
    pins <= ~v;
  endtask
  task automatic edge2();
    second_in <= 1'b0;
    repeat (3) @(posedge clk);
    second_in <= 1'b1;
  endtask
  task automatic put(input logic [7:0] v);
    pins <= v;
  endtask
endmodule
`default_nettype wire

/* bench/upm_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "upm_map.svh"
module upm_port_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q, k;
  logic [7:0] a_in, a_out, a_oe, b_in, b_out, b_oe;
  logic pready, pslverr, e, a_stb, a_sin, a_sp, a_soe, b_stb, b_sin, b_sp, b_soe, irq, dma, late;
  int n_fail = 0;
  int check_count = 0;
  always #2.5 clk = ~clk;
  upm_port i_dut (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .port_a_in(a_in), .port_a_out(a_out), .port_a_oe(a_oe), .port_a_strobe_in(a_stb),
    .port_a_second_in(a_sin), .port_a_second_pin(a_sp), .port_a_second_oe(a_soe),
    .port_b_in(b_in), .port_b_out(b_out), .port_b_oe(b_oe), .port_b_strobe_in(b_stb),
    .port_b_second_in(b_sin), .port_b_second_pin(b_sp), .port_b_second_oe(b_soe),
    .port_irq(irq), .dma_request_out(dma)
  );
  upm_periph i_pa (.clk, .second_pin(a_sp), .strobe(a_stb), .second_in(a_sin), .pins(a_in));
  upm_periph i_pb (.clk, .second_pin(b_sp), .strobe(b_stb), .second_in(b_sin), .pins(b_in));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic chk1(input string s, input logic x, input logic g);
    chk(s, {31'h0, x}, {31'h0, g});
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_fail++;
      end_of_test();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wt(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) begin
      n_fail++;
      end_of_test();
    end
  endtask
  task automatic tmo();
    if (late) begin
      n_fail++;
      end_of_test();
    end
  endtask
  task automatic t_regs();
    apb(1'b0, `UPM_OFF_ACTL, 32'h0000_0000);
    chk("ctl a reset", 32'h0000_0000, q);
    apb(1'b1, `UPM_OFF_BCTL, 32'h0000_005A);
    apb(1'b0, `UPM_OFF_BCTL, 32'h0000_0000);
    chk("ctl b", 32'h0000_005A, q);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk1("unmapped", 1'b1, e);
    $display("regs done");
  endtask
  task automatic t_bitio();
    i_pa.put(8'h3C);
    apb(1'b1, `UPM_OFF_ACTL, 32'h0000_0080);
    apb(1'b1, `UPM_OFF_ADIR, 32'h0000_000F);
    apb(1'b1, `UPM_OFF_ADATA, 32'h0000_00A5);
    apb(1'b0, `UPM_OFF_ADATA, 32'h0000_0000);
    chk("mixed read", 32'h0000_0035, q);
    chk("out latch", 32'h0000_00A5, {24'h0, a_out});
    chk("out enable", 32'h0000_000F, {24'h0, a_oe});
    apb(1'b1, `UPM_OFF_BCTL, 32'h0000_00AA);
    apb(1'b1, `UPM_OFF_BDIR, 32'h0000_00F0);
    apb(1'b1, `UPM_OFF_BDATA, 32'h0000_005A);
    apb(1'b1, `UPM_OFF_GENCTL, 32'h0000_0060);
    chk1("b fixed on", 1'b0, b_sp);
    chk1("b second oe", 1'b1, b_soe);
    chk("b out latch", 32'h0000_005A, {24'h0, b_out});
    chk("b out enable", 32'h0000_00F0, {24'h0, b_oe});
    i_pb.send(8'h77, 1'b0, late);
    apb(1'b0, `UPM_OFF_STATUS, 32'h0000_0000);
    chk("b edge flag", 32'h0000_0004, q);
    chk1("dma in bit io", 1'b0, dma);
    apb(1'b1, `UPM_OFF_STATUS, 32'h0000_0004);
    apb(1'b0, `UPM_OFF_STATUS, 32'h0000_0000);
    chk("b flag cleared", 32'h0000_0000, q);
    $display("bit io done");
  endtask
  task automatic t_ilk();
    apb(1'b1, `UPM_OFF_GENCTL, 32'h0000_0000);
    apb(1'b1, `UPM_OFF_ACTL, 32'h0000_0032);
    apb(1'b1, `UPM_OFF_ADIR, 32'h0000_0000);
    apb(1'b1, `UPM_OFF_GENCTL, 32'h0000_0010);
    i_pa.send(8'h11, 1'b1, late);
    tmo();
    i_pa.send(8'h22, 1'b1, late);
    tmo();
    chk1("full negates", 1'b1, a_sp);
    // strobe while the port is not ready must be dropped
    i_pa.send(8'h33, 1'b0, late);
    chk1("dma", 1'b1, dma);
    apb(1'b0, `UPM_OFF_STATUS, 32'h0000_0000);
    chk("status full", 32'h0000_0001, q);
    apb(1'b0, `UPM_OFF_ADATA, 32'h0000_0000);
    chk("first byte", 32'h0000_0011, q);
    apb(1'b0, `UPM_OFF_ADATA, 32'h0000_0000);
    chk("second byte", 32'h0000_0022, q);
    apb(1'b0, `UPM_OFF_STATUS, 32'h0000_0000);
    chk("status empty", 32'h0000_0000, q);
    $display("interlocked done");
  endtask
  task automatic t_pulse();
    apb(1'b1, `UPM_OFF_GENCTL, 32'h0000_0000);
    apb(1'b1, `UPM_OFF_ACTL, 32'h0000_003A);
    apb(1'b1, `UPM_OFF_GENCTL, 32'h0000_0010);
    wt(a_sp, 1'b0);
    k = 32'h0000_0000;
    while (a_sp === 1'b0 && k < 32'h0000_000A) begin
      @(posedge clk);
      k++;
    end
    chk("pulse length", {29'h0, `UPM_PULSE_CYC}, k);
    i_pa.send(8'h44, 1'b0, late);
    apb(1'b0, `UPM_OFF_STATUS, 32'h0000_0000);
    chk("late strobe", 32'h0000_0001, q);
    apb(1'b1, `UPM_OFF_GENCTL, 32'h0000_0000);
    apb(1'b0, `UPM_OFF_STATUS, 32'h0000_0000);
    chk("disabled empty", 32'h0000_0000, q);
    $display("pulsed done");
  endtask
  task automatic t_sec();
    apb(1'b1, `UPM_OFF_ACTL, 32'h0000_0004);
    apb(1'b1, `UPM_OFF_GENCTL, 32'h0000_0010);
    i_pa.edge2();
    wt(irq, 1'b1);
    apb(1'b1, `UPM_OFF_STATUS, 32'h0000_0001);
    apb(1'b0, `UPM_OFF_STATUS, 32'h0000_0000);
    chk("flag kept", 32'h0000_0002, q);
    apb(1'b1, `UPM_OFF_ACTL, 32'h0000_0000);
    @(posedge clk);
    chk1("irq masked", 1'b0, irq);
    apb(1'b1, `UPM_OFF_STATUS, 32'h0000_0002);
    apb(1'b0, `UPM_OFF_STATUS, 32'h0000_0000);
    chk("flag cleared", 32'h0000_0000, q);
    $display("second input done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_bitio();
    t_ilk();
    t_pulse();
    t_sec();
    end_of_test();
  end
endmodule
`default_nettype wire
